// ==== aitg_pkg.sv ====
// Constants, register map and types shared by the tail-group executor.
// Assumes a 32-bit AXI4-Lite bus with byte addresses, one word a register.
package aitg_pkg;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 8;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = 4;

  localparam logic [ADDR_W-1:0] ADDR_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_WORK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_FADDR = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_FDATA = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_WDT = 8'h18;

  localparam int ST_CARRY = 0;
  localparam int ST_DCARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam int ST_ASLEEP = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_UNKNOWN = 7;
  localparam int CTRL_WAKE = 0;
  localparam int WDT_PRE_LSB = 8;

  localparam int INS_DEST = 7;
  localparam int INS_OP_LSB = 8;
  localparam logic [5:0] ENC_RRF = 6'h0c;
  localparam logic [5:0] ENC_XOR = 6'h06;
  localparam logic [4:0] ENC_SUB = 5'h1e;
  localparam logic [INSTR_W-1:0] ENC_SLEEP = 14'h0063;

  localparam logic FLAG_RST = 1'b0;
  localparam logic PD_N_RST = 1'b1;
  localparam logic TO_N_RST = 1'b1;
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_Q1 = 5'h02,
    PH_Q2 = 5'h04,
    PH_Q3 = 5'h08,
    PH_Q4 = 5'h10
  } aitg_phase_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_RRF = 3'h1,
    OP_SLEEP = 3'h2,
    OP_SUB = 3'h3,
    OP_XOR = 3'h4
  } aitg_op_e;

  function automatic aitg_op_e aitg_decode(input logic [INSTR_W-1:0] ins);
    if (ins[13:8] == ENC_XOR) return OP_XOR;
    if (ins[13:8] == ENC_RRF) return OP_RRF;
    if (ins[13:9] == ENC_SUB) return OP_SUB;
    if (ins == ENC_SLEEP) return OP_SLEEP;
    return OP_NONE;
  endfunction
endpackage

// ==== aitg_alu.sv ====
// Result and flag logic for the rotate, subtract and XOR instructions of the group.
// Purely combinational; the caller picks which flags it keeps.
`timescale 1ns/1ps
`default_nettype none
module aitg_alu
  import aitg_pkg::*;
#(
  parameter int W = DATA_W
) (
  input var aitg_op_e op,
  input wire logic [W-1:0] work,
  input wire logic [W-1:0] opnd,
  input wire logic [W-1:0] imm,
  input wire logic carry_in,
  output logic [W-1:0] result,
  output logic carry,
  output logic dcarry,
  output logic zero
);
  logic [W:0] diff;
  logic [NIB_W:0] ndiff;

  assign diff = {1'b0, imm} - {1'b0, work};
  assign ndiff = {1'b0, imm[NIB_W-1:0]} - {1'b0, work[NIB_W-1:0]};

  always_comb begin
    result = work;
    carry = carry_in;
    dcarry = 1'b0;
    unique case (op)
      OP_RRF: begin
        result = {carry_in, opnd[W-1:1]};
        carry = opnd[0];
      end
      OP_SUB: begin
        result = diff[W-1:0];
        carry = ~diff[W];
        dcarry = ~ndiff[NIB_W];
      end
      OP_XOR: result = work ^ opnd;
      default: ;
    endcase
    zero = (result == '0);
  end
endmodule
`default_nettype wire

// ==== aitg_wdt.sv ====
// Watchdog counter behind a free-running prescaler, with a clear input.
// Assumes the clear is a one-cycle pulse in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module aitg_wdt #(
  parameter int CNT_W = 8,
  parameter int PRE_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  output logic [CNT_W-1:0] cnt,
  output logic [PRE_W-1:0] pre
);
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      pre <= '0;
      cnt <= '0;
    end else begin
      pre <= pre + 1'b1;
      if (&pre) cnt <= cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== aitg_core.sv ====
// Executor for the rotate, sleep, subtract-from-literal and XOR group,
// stepping each instruction through four quarter phases Q1 to Q4.
// Assumes one AXI4-Lite master and a synchronous active-low reset.
// Notes on behaviour
// - Rotate file register right through carry; only carry changes.
// - Rotate destination bit 0 writes work register, 1 writes file.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep clears power-down status low and sets time-out status high.
// - Sleep runs through Q1 to Q4 like the others and halts the oscillator in its Q4.
// - Subtract computes literal minus work into work; updates C, DC, Z.
// - XOR of work and file; destination bit picks target; only Z.
// - XOR is recognised by top six bits 000110, then d and address.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module aitg_core
  import aitg_pkg::*;
#(
  parameter int WDT_CNT_W = 8,
  parameter int WDT_PRE_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DW-1:0] s_axi_wdata,
  input wire logic [AXI_SW-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic osc_halt
);
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [AXI_DW-1:0] rdata_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [AXI_DW-1:0] wdata_ff;
  logic [AXI_SW-1:0] wstrb_ff;

  aitg_phase_e phase_ff;
  aitg_op_e op_ff;
  logic [INSTR_W-1:0] instr_ff;
  logic [DATA_W-1:0] work_ff;
  logic [DATA_W-1:0] opnd_ff;
  logic [DATA_W-1:0] res_ff;
  logic c_res_ff;
  logic dc_res_ff;
  logic z_res_ff;
  logic [FADDR_W-1:0] faddr_ff;
  logic c_ff;
  logic dc_ff;
  logic z_ff;
  logic pd_n_ff;
  logic to_n_ff;
  logic asleep_ff;
  logic unknown_ff;
  logic [DATA_W-1:0] file_mem [2**FADDR_W];

  logic [DATA_W-1:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic [WDT_CNT_W-1:0] wdt_cnt;
  logic [WDT_PRE_W-1:0] wdt_pre;

  logic busy;
  logic wr_do;
  logic wr_mapped;
  logic wr_ok;
  logic start;
  logic sleep_q4;
  logic dest_file;
  logic [AXI_DW-1:0] wr_val;
  logic [AXI_DW-1:0] rd_word;
  logic rd_mapped;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_INSTR || a == ADDR_WORK || a == ADDR_FADDR ||
           a == ADDR_FDATA || a == ADDR_STATUS || a == ADDR_CTRL ||
           a == ADDR_WDT;
  endfunction

  function automatic logic [AXI_DW-1:0] merge_strb(
      input logic [AXI_DW-1:0] old_v, input logic [AXI_DW-1:0] new_v,
      input logic [AXI_SW-1:0] strb);
    logic [AXI_DW-1:0] m;
    m = old_v;
    for (int i = 0; i < AXI_SW; i++) begin
      if (strb[i]) m[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return m;
  endfunction

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign osc_halt = asleep_ff;

  assign busy = (phase_ff != PH_IDLE);
  assign wr_do = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_mapped = is_mapped(awaddr_ff);
  // Writes during execution would race the Q4 write-back, so refuse them
  assign wr_ok = wr_mapped && !busy &&
                 !(awaddr_ff == ADDR_INSTR && asleep_ff);
  assign start = wr_do && wr_ok && awaddr_ff == ADDR_INSTR;
  assign sleep_q4 = (phase_ff == PH_Q4) && (op_ff == OP_SLEEP);
  assign dest_file = instr_ff[INS_DEST];

  always_comb begin
    wr_val = '0;
    unique case (awaddr_ff)
      ADDR_INSTR: wr_val = merge_strb(AXI_DW'(instr_ff), wdata_ff, wstrb_ff);
      ADDR_WORK: wr_val = merge_strb(AXI_DW'(work_ff), wdata_ff, wstrb_ff);
      ADDR_FADDR: wr_val = merge_strb(AXI_DW'(faddr_ff), wdata_ff, wstrb_ff);
      default: wr_val = merge_strb('0, wdata_ff, wstrb_ff);
    endcase
  end

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_held_ff <= 1'b0;
    end else if (!aw_held_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_do) begin
      w_held_ff <= 1'b0;
    end else if (!w_held_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= !wr_mapped ? RESP_DECERR :
                  (wr_ok ? RESP_OKAY : RESP_SLVERR);
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_comb begin
    rd_word = '0;
    rd_mapped = is_mapped(s_axi_araddr);
    unique case (s_axi_araddr)
      ADDR_INSTR: rd_word = AXI_DW'(instr_ff);
      ADDR_WORK: rd_word = AXI_DW'(work_ff);
      ADDR_FADDR: rd_word = AXI_DW'(faddr_ff);
      ADDR_FDATA: rd_word = AXI_DW'(file_mem[faddr_ff]);
      ADDR_STATUS: begin
        rd_word[ST_CARRY] = c_ff;
        rd_word[ST_DCARRY] = dc_ff;
        rd_word[ST_ZERO] = z_ff;
        rd_word[ST_PD_N] = pd_n_ff;
        rd_word[ST_TO_N] = to_n_ff;
        rd_word[ST_ASLEEP] = asleep_ff;
        rd_word[ST_BUSY] = busy;
        rd_word[ST_UNKNOWN] = unknown_ff;
      end
      ADDR_WDT: rd_word = AXI_DW'(wdt_cnt) |
                          (AXI_DW'(wdt_pre) << WDT_PRE_LSB);
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      rdata_ff <= rd_word;
    end else if (!rvalid_ff || s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Quarter-phase sequencer: decode, read, process, write back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff <= PH_IDLE;
    end else begin
      unique case (phase_ff)
        PH_IDLE: if (start) phase_ff <= PH_Q1;
        PH_Q1: phase_ff <= PH_Q2;
        PH_Q2: phase_ff <= PH_Q3;
        PH_Q3: phase_ff <= PH_Q4;
        PH_Q4: phase_ff <= PH_IDLE;
        default: phase_ff <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_ff <= INSTR_RST;
      op_ff <= OP_NONE;
      unknown_ff <= 1'b0;
    end else if (start) begin
      instr_ff <= wr_val[INSTR_W-1:0];
      unknown_ff <= 1'b0;
    end else if (phase_ff == PH_Q1) begin
      op_ff <= aitg_decode(instr_ff);
      unknown_ff <= (aitg_decode(instr_ff) == OP_NONE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opnd_ff <= '0;
      res_ff <= '0;
      c_res_ff <= FLAG_RST;
      dc_res_ff <= FLAG_RST;
      z_res_ff <= FLAG_RST;
    end else if (phase_ff == PH_Q2) begin
      opnd_ff <= file_mem[instr_ff[FADDR_W-1:0]];
    end else if (phase_ff == PH_Q3) begin
      res_ff <= alu_res;
      c_res_ff <= alu_c;
      dc_res_ff <= alu_dc;
      z_res_ff <= alu_z;
    end
  end

  aitg_alu #(
    .W(DATA_W)
  ) u_alu (
    .op(op_ff),
    .work(work_ff),
    .opnd(opnd_ff),
    .imm(instr_ff[DATA_W-1:0]),
    .carry_in(c_ff),
    .result(alu_res),
    .carry(alu_c),
    .dcarry(alu_dc),
    .zero(alu_z)
  );

  aitg_wdt #(
    .CNT_W(WDT_CNT_W),
    .PRE_W(WDT_PRE_W)
  ) u_wdt (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(sleep_q4),
    .cnt(wdt_cnt),
    .pre(wdt_pre)
  );

  always_ff @(posedge aclk) begin
    if (wr_do && wr_ok && awaddr_ff == ADDR_FDATA) begin
      file_mem[faddr_ff] <= wr_val[DATA_W-1:0];
    end else if (phase_ff == PH_Q4 && dest_file &&
                 (op_ff == OP_RRF || op_ff == OP_XOR)) begin
      file_mem[instr_ff[FADDR_W-1:0]] <= res_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      work_ff <= WORK_RST;
      faddr_ff <= '0;
    end else if (wr_do && wr_ok && awaddr_ff == ADDR_WORK) begin
      work_ff <= wr_val[DATA_W-1:0];
    end else if (wr_do && wr_ok && awaddr_ff == ADDR_FADDR) begin
      faddr_ff <= wr_val[FADDR_W-1:0];
    end else if (phase_ff == PH_Q4) begin
      if (op_ff == OP_SUB) work_ff <= res_ff;
      if ((op_ff == OP_RRF || op_ff == OP_XOR) && !dest_file) begin
        work_ff <= res_ff;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_ff <= FLAG_RST;
      dc_ff <= FLAG_RST;
      z_ff <= FLAG_RST;
      pd_n_ff <= PD_N_RST;
      to_n_ff <= TO_N_RST;
    end else if (wr_do && wr_ok && awaddr_ff == ADDR_STATUS &&
                 wstrb_ff[0]) begin
      c_ff <= wdata_ff[ST_CARRY];
      dc_ff <= wdata_ff[ST_DCARRY];
      z_ff <= wdata_ff[ST_ZERO];
    end else if (phase_ff == PH_Q4) begin
      unique case (op_ff)
        OP_RRF: c_ff <= c_res_ff;
        OP_SUB: begin
          c_ff <= c_res_ff;
          dc_ff <= dc_res_ff;
          z_ff <= z_res_ff;
        end
        OP_XOR: z_ff <= z_res_ff;
        OP_SLEEP: begin
          pd_n_ff <= 1'b0;
          to_n_ff <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Sleep entry wins over a wake request in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asleep_ff <= 1'b0;
    end else if (sleep_q4) begin
      asleep_ff <= 1'b1;
    end else if (wr_do && wr_ok && awaddr_ff == ADDR_CTRL &&
                 wstrb_ff[0] && wdata_ff[CTRL_WAKE]) begin
      asleep_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sleep_run;
    phase_ff == PH_Q1 && aitg_decode(instr_ff) == OP_SLEEP ##1
    phase_ff == PH_Q2 && !asleep_ff ##1
    phase_ff == PH_Q3 && !asleep_ff ##1 phase_ff == PH_Q4;
  endsequence

  chk_rrf_carry_only: assert property (
    phase_ff == PH_Q4 && op_ff == OP_RRF |=>
    c_ff == $past(opnd_ff[0]) && z_ff == $past(z_ff) &&
    dc_ff == $past(dc_ff))
    else $error("rotate carry wrong");

  chk_rrf_dest_sel: assert property (
    phase_ff == PH_Q4 && op_ff == OP_RRF |=>
    work_ff == ($past(instr_ff[INS_DEST]) ? $past(work_ff) :
                {$past(c_ff), $past(opnd_ff[DATA_W-1:1])}))
    else $error("rotate destination wrong");

  chk_sleep_wdt_clr: assert property (
    sleep_q4 |=> wdt_cnt == '0 && wdt_pre == '0)
    else $error("watchdog not cleared");

  chk_sleep_status: assert property (
    sleep_q4 |=> !pd_n_ff && to_n_ff)
    else $error("sleep status wrong");

  chk_sleep_halt_q4: assert property (
    s_sleep_run |=> asleep_ff && phase_ff == PH_IDLE)
    else $error("sleep not entered at Q4");

  chk_sub_result: assert property (
    phase_ff == PH_Q4 && op_ff == OP_SUB |=>
    work_ff == DATA_W'($past(instr_ff[DATA_W-1:0]) - $past(work_ff)))
    else $error("subtract result wrong");

  chk_xor_dest_sel: assert property (
    phase_ff == PH_Q4 && op_ff == OP_XOR |=>
    work_ff == ($past(instr_ff[INS_DEST]) ? $past(work_ff) :
                ($past(work_ff) ^ $past(opnd_ff))) && c_ff == $past(c_ff))
    else $error("xor destination wrong");

  chk_xor_decode: assert property (
    phase_ff == PH_Q1 && instr_ff[13:8] == ENC_XOR |=> op_ff == OP_XOR)
    else $error("xor not decoded");

  chk_sub_borrow: assert property (
    phase_ff == PH_Q4 && op_ff == OP_SUB |=>
    c_ff == ($past(instr_ff[DATA_W-1:0]) >= $past(work_ff)) &&
    z_ff == (work_ff == '0))
    else $error("subtract flags wrong");

  chk_xor_zero: assert property (
    phase_ff == PH_Q4 && op_ff == OP_XOR |=>
    z_ff == ($past(work_ff) == $past(opnd_ff)))
    else $error("xor zero flag wrong");
endmodule
`default_nettype wire

// ==== aitg_core_test.sv ====
// Self-checking bench for the tail-group executor, driven over AXI4-Lite.
// Assumes aitg_pkg, aitg_alu, aitg_wdt and aitg_core are compiled first.
`timescale 1ns/1ps
`default_nettype none
module aitg_core_test
  import aitg_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [AXI_DW-1:0] wdata = '0;
  logic [AXI_SW-1:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, osc_halt;
  logic [1:0] bresp, rresp, rsp;
  logic [AXI_DW-1:0] rdata, rd;
  logic [7:0] sw [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
  logic [7:0] sk [4] = '{8'h02, 8'h02, 8'h02, 8'h10};
  logic [7:0] res;
  logic c, dc, z;
  int failures = 0;
  int n_tests = 0;

  always #12.5 aclk = ~aclk;

  aitg_core #(.WDT_CNT_W(8), .WDT_PRE_W(8)) aitg_core_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .osc_halt(osc_halt)
  );

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Address and data are each released at their own acceptance edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, rsp);
    check("write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] exp);
    axr(a, rd, rsp);
    check(what, {rd[29:0], rsp}, {exp[29:0], RESP_OKAY});
  endtask

  // Starts an instruction and polls until the busy bit drops
  task automatic run(input logic [13:0] ins);
    int i;
    wr(ADDR_INSTR, {18'h0, ins});
    for (i = 0; i < 20; i++) begin
      axr(ADDR_STATUS, rd, rsp);
      if (rd[ST_BUSY] === 1'b0) break;
    end
    check("run idle", {31'h0, rd[ST_BUSY]}, 32'h0);
  endtask

  initial begin
    #250000;
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("status reset", ADDR_STATUS, 32'h0000_0018);
    rdc("work reset", ADDR_WORK, 32'h0);
    axr(8'h40, rd, rsp);
    check("unmapped read", {rd[29:0], rsp}, {30'h0, RESP_DECERR});
    axw(8'h40, 32'h1, rsp);
    check("unmapped write", {30'h0, rsp}, {30'h0, RESP_DECERR});
    wr(ADDR_FADDR, 32'h5);
    wr(ADDR_FDATA, 32'h0000_00e6);
    wr(ADDR_STATUS, 32'h0);
    run(14'h0c05);
    rdc("rot work", ADDR_WORK, 32'h0000_0073);
    rdc("rot file kept", ADDR_FDATA, 32'h0000_00e6);
    rdc("rot flags", ADDR_STATUS, 32'h0000_0018);
    wr(ADDR_STATUS, 32'h7);
    run(14'h0c85);
    rdc("rot file", ADDR_FDATA, 32'h0000_00f3);
    rdc("rot carry out", ADDR_STATUS, 32'h0000_001e);
    rdc("rot work kept", ADDR_WORK, 32'h0000_0073);
    run(14'h0c85);
    rdc("rot file 2", ADDR_FDATA, 32'h0000_0079);
    rdc("rot carry set", ADDR_STATUS, 32'h0000_001f);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_WORK, {24'h0, sw[i]});
      run({ENC_SUB, i[0], sk[i]});
      res = sk[i] - sw[i];
      c = sk[i] >= sw[i];
      dc = sk[i][3:0] >= sw[i][3:0];
      z = res == 8'h0;
      rdc("sub work", ADDR_WORK, {24'h0, res});
      rdc("sub flags", ADDR_STATUS, {27'h0, 2'b11, z, dc, c});
    end
    wr(ADDR_FADDR, 32'h0000_007f);
    wr(ADDR_FDATA, 32'h0000_00af);
    wr(ADDR_WORK, 32'h0000_00b5);
    wr(ADDR_STATUS, 32'h5);
    run(14'h06ff);
    rdc("xor file", ADDR_FDATA, 32'h0000_001a);
    rdc("xor work kept", ADDR_WORK, 32'h0000_00b5);
    rdc("xor flags", ADDR_STATUS, 32'h0000_0019);
    wr(ADDR_WORK, 32'h0000_001a);
    run(14'h067f);
    rdc("xor work", ADDR_WORK, 32'h0);
    rdc("xor file kept", ADDR_FDATA, 32'h0000_001a);
    rdc("xor zero", ADDR_STATUS, 32'h0000_001d);
    // Neighbouring pattern must not be taken for the XOR
    run(14'h0e7f);
    rdc("near miss work", ADDR_WORK, 32'h0);
    rdc("near miss file", ADDR_FDATA, 32'h0000_001a);
    rdc("near miss status", ADDR_STATUS, 32'h0000_009d);
    repeat (600) @(posedge aclk);
    axr(ADDR_WDT, rd, rsp);
    check("wdt running", {31'h0, rd[7:0] != 8'h0}, 32'h1);
    run(ENC_SLEEP);
    check("halted", {31'h0, osc_halt}, 32'h1);
    axr(ADDR_STATUS, rd, rsp);
    check("sleep status", rd & 32'h0000_007f, 32'h0000_0035);
    axr(ADDR_WDT, rd, rsp);
    check("wdt cleared", {31'h0, rd[7:0] == 8'h0 && rd[15:8] < 8'h40},
          32'h1);
    axw(ADDR_INSTR, 32'h0000_3c00, rsp);
    check("asleep refuse", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    rdc("instr kept", ADDR_INSTR, {18'h0, ENC_SLEEP});
    wr(ADDR_CTRL, 32'h1);
    repeat (2) @(posedge aclk);
    check("awake", {31'h0, osc_halt}, 32'h0);
    axr(ADDR_STATUS, rd, rsp);
    check("woken status", rd & 32'h0000_007f, 32'h0000_0015);
    tally_and_finish();
  end
endmodule
`default_nettype wire
